//--- rtl/port_d_wake_defines.svh
`ifndef PORT_D_WAKE_DEFINES_SVH
`define PORT_D_WAKE_DEFINES_SVH

// filter intervals in ms, as printed
`define FILT_SLOW_MS 32
`define FILT_MID_MS 8
`define FILT_FAST_MS 2
// core clock period in ns
`define CLK_PERIOD_NS 10
// filter interval in clock cycles (ms -> ns / period)
`define FILT_CYCLES(ms) ((ms) * 1000000 / `CLK_PERIOD_NS)
// filter clock select encodings
`define SEL_SLOW 2'h0
`define SEL_MID 2'h1
`define SEL_FAST 2'h2
// reset values
`define SEL_RESET 2'h0

`endif

//--- rtl/port_d_wake_pkg.sv
package port_d_wake_pkg;

    // detection method, fixed by configuration
    typedef enum logic {DETECT_LEVEL, DETECT_FILTER} detect_mode_t;

    // power state seen by this port
    typedef enum logic [1:0] {PWR_RUN, PWR_HALT, PWR_STOP} power_state_t;

    // wake requests out of the port
    typedef struct packed {
        logic halt_release;
        logic stop_release;
        logic halt_allowed;
        logic stop_allowed;
    } wake_req_t;

endpackage

//--- rtl/pin_sync3.sv
`timescale 1ns/1ns
`include "port_d_wake_defines.svh"

// three-stage synchroniser, change taken once stages two and three agree
module pin_sync3
    import port_d_wake_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [3:0] pin_async,
    output logic [3:0] pin_sync
);

    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] s3;
        logic [3:0] q;
    } sync_state_t;

    sync_state_t cur;
    sync_state_t next_cur;

    // shift; first stage only feeds the second
    always_comb
    begin
        next_cur = cur;
        next_cur.s1 = pin_async;
        next_cur.s2 = cur.s1;
        next_cur.s3 = cur.s2;
        // accept only a level that stayed two samples
        for (int i = 0; i < 4; i++)
        begin
            if (cur.s2[i] == cur.s3[i])
            begin
                next_cur.q[i] = cur.s3[i];
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            cur <= '0;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign pin_sync = cur.q;

endmodule

//--- rtl/debounce_filter.sv
`timescale 1ns/1ns
`include "port_d_wake_defines.svh"

// noise filter: input must hold a level for a whole interval to pass
module debounce_filter
    import port_d_wake_pkg::*;
#(
    parameter int unsigned SLOW_CYCLES = `FILT_CYCLES(`FILT_SLOW_MS),
    parameter int unsigned MID_CYCLES = `FILT_CYCLES(`FILT_MID_MS),
    parameter int unsigned FAST_CYCLES = `FILT_CYCLES(`FILT_FAST_MS)
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [1:0] sel,
    input wire logic raw,
    output logic filtered
);

    typedef struct packed {
        logic [31:0] count;
        logic level;
    } filt_state_t;

    filt_state_t cur;
    filt_state_t next_cur;
    logic [31:0] limit;

    // interval chosen by the clock select
    always_comb
    begin
        case (sel)
            `SEL_MID: limit = MID_CYCLES;
            `SEL_FAST: limit = FAST_CYCLES;
            default: limit = SLOW_CYCLES;
        endcase
    end

    // restart the count whenever the input agrees with the held level; pulses shorter than limit vanish
    always_comb
    begin
        next_cur = cur;
        if (raw == cur.level)
        begin
            next_cur.count = '0;
        end
        else if (cur.count + 32'h1 >= limit)
        begin
            next_cur.count = '0;
            next_cur.level = raw;
        end
        else
        begin
            next_cur.count = cur.count + 32'h1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            cur <= '0;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign filtered = cur.level;

endmodule

//--- rtl/port_d_wake_detect.sv
`timescale 1ns/1ns
`include "port_d_wake_defines.svh"
// Contract
// - filtered edge either way sets start flag
// - debounce armed: any filtered OR change sets flag
// - flag set blocks detection until re-arm
// - arm clears all three start flags
// - start flag sets halt release request
// - level mode: pin high releases halt
// - level mode: halt only with pins low
// - debounce: filtered OR change releases halt
// - debounce: halt allowed at any level
// - interrupt enabled: start flag requests interrupt
// - stop allowed only with pins low
// - level mode: pin high releases stop
// - debounce stop release needs both enables
// - after debounce stop release enter halt
// - early return low goes back to stop
// - four inputs ORed before detection
// - level mode rising OR sets flag
// - filter interval 32, 8, 2 ms selectable
module port_d_wake_detect
    import port_d_wake_pkg::*;
#(
    parameter int unsigned SLOW_CYCLES = `FILT_CYCLES(`FILT_SLOW_MS),
    parameter int unsigned MID_CYCLES = `FILT_CYCLES(`FILT_MID_MS),
    parameter int unsigned FAST_CYCLES = `FILT_CYCLES(`FILT_FAST_MS)
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [3:0] wake_port,
    input wire logic debounce_strap,
    input wire logic arm_wake_instruction,
    input wire logic filter_clock_select_instr,
    input wire logic [1:0] filter_clock_select_value,
    input wire logic port_stop_release_enable,
    input wire logic interrupt_enable0,
    input wire logic halt_release_ack0,
    input wire logic porta_set,
    input wire logic portc_set,
    input wire power_state_t power_state,
    output logic port_start_cond_flag,
    output logic porta_start_cond_flag,
    output logic portc_start_cond_flag,
    output logic port_switch_enable_flag,
    output logic halt_release_request0,
    output logic interrupt_request,
    output logic halt_release,
    output logic stop_release,
    output logic return_to_stop,
    output logic halt_allowed,
    output logic stop_allowed
);

    // whole module state
    typedef struct packed {
        detect_mode_t mode;     // captured once after reset
        logic mode_taken;
        logic [1:0] sel;        // filter clock select
        logic sef;              // switch enable
        logic scf;              // this port start flag
        logic scf_a;            // first wake port flag
        logic scf_c;            // second wake port flag
        logic hrf;              // halt release request 0
        logic irq;
        logic prev_or;          // last combined level seen
        logic prev_filt;        // last filtered level seen
        logic stop_wake;        // woke from stop, waiting for filter
        wake_req_t req;
        logic back_stop;
    } core_state_t;

    core_state_t cur;
    core_state_t next_cur;
    logic [3:0] pins;           // synchronised pins
    logic any_high;             // OR of the port
    logic filt;                 // filtered OR
    logic set_flag;

    pin_sync3 pin_sync3_inst (
        .clock(clock),
        .rst(rst),
        .pin_async(wake_port),
        .pin_sync(pins)
    );

    assign any_high = |pins;

    debounce_filter #(
        .SLOW_CYCLES(SLOW_CYCLES),
        .MID_CYCLES(MID_CYCLES),
        .FAST_CYCLES(FAST_CYCLES)
    ) debounce_filter_inst (
        .clock(clock),
        .rst(rst),
        .sel(cur.sel),
        .raw(any_high),
        .filtered(filt)
    );

    // detection: only when armed and the flag still clear
    always_comb
    begin
        set_flag = 1'b0;
        if (cur.mode_taken && cur.sef && !cur.scf)
        begin
            if (cur.mode == DETECT_FILTER)
            begin
                set_flag = (filt != cur.prev_filt);
            end
            else
            begin
                set_flag = any_high && !cur.prev_or;
            end
        end
    end

    // next-state for flags, requests and power gating
    always_comb
    begin
        next_cur = cur;
        next_cur.prev_or = any_high;
        next_cur.prev_filt = filt;
        // strap captured once, one cycle after release of reset
        if (!cur.mode_taken)
        begin
            next_cur.mode = debounce_strap ? DETECT_FILTER : DETECT_LEVEL;
            next_cur.mode_taken = 1'b1;
        end
        if (filter_clock_select_instr)
        begin
            next_cur.sel = filter_clock_select_value;
        end
        // arm: clear all three flags and enable; sets below still win
        if (arm_wake_instruction)
        begin
            next_cur.scf = 1'b0;
            next_cur.scf_a = 1'b0;
            next_cur.scf_c = 1'b0;
            next_cur.sef = 1'b1;
        end
        if (porta_set)
        begin
            next_cur.scf_a = 1'b1;
        end
        if (portc_set)
        begin
            next_cur.scf_c = 1'b1;
        end
        // request flag cleared by core acknowledge, set wins
        if (halt_release_ack0)
        begin
            next_cur.hrf = 1'b0;
            next_cur.irq = 1'b0;
        end
        if (set_flag)
        begin
            next_cur.scf = 1'b1;
            next_cur.hrf = 1'b1;
            // a pending request is never dropped by a later set while disabled
            if (interrupt_enable0)
            begin
                next_cur.irq = 1'b1;
            end
            next_cur.stop_wake = 1'b0;
        end
        // halt release pulse on the setting edge
        next_cur.req.halt_release = set_flag;
        // stop release straight from the raw OR
        next_cur.req.stop_release = 1'b0;
        if (power_state == PWR_STOP && cur.sef && !cur.scf && any_high)
        begin
            if (cur.mode == DETECT_LEVEL)
            begin
                next_cur.req.stop_release = 1'b1;
            end
            else if (port_stop_release_enable)
            begin
                next_cur.req.stop_release = 1'b1;
                // a flag landing now ends the wait; a stale mark would fake a drop
                if (!set_flag)
                begin
                    next_cur.stop_wake = 1'b1;
                end
            end
        end
        // pin fell before the filter validated it
        next_cur.back_stop = 1'b0;
        if (cur.stop_wake && !any_high && !set_flag)
        begin
            next_cur.back_stop = 1'b1;
            next_cur.stop_wake = 1'b0;
        end
        next_cur.req.halt_allowed = (cur.mode == DETECT_FILTER) || !any_high;
        next_cur.req.stop_allowed = !any_high;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            cur <= '0;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    // outputs straight from state
    assign port_start_cond_flag = cur.scf;
    assign porta_start_cond_flag = cur.scf_a;
    assign portc_start_cond_flag = cur.scf_c;
    assign port_switch_enable_flag = cur.sef;
    assign halt_release_request0 = cur.hrf;
    assign interrupt_request = cur.irq;
    assign halt_release = cur.req.halt_release;
    assign stop_release = cur.req.stop_release;
    assign return_to_stop = cur.back_stop;
    assign halt_allowed = cur.req.halt_allowed;
    assign stop_allowed = cur.req.stop_allowed;

    // flag set by detection raises request in the same cycle
    a_flag_request: assert property (@(posedge clock) disable iff (rst)
        $rose(cur.scf) |-> cur.hrf)
        else $error("start flag set without halt request");

    // arm clears all three unless a set lands
    a_arm_clears: assert property (@(posedge clock) disable iff (rst)
        arm_wake_instruction && !set_flag && !porta_set && !portc_set
        |=> !cur.scf && !cur.scf_a && !cur.scf_c)
        else $error("arm did not clear flags");

    // set flag holds until arm
    a_flag_holds: assert property (@(posedge clock) disable iff (rst)
        cur.scf && !arm_wake_instruction |=> cur.scf)
        else $error("start flag dropped without arm");

    // stop gate follows pins
    a_stop_gate: assert property (@(posedge clock) disable iff (rst)
        any_high |=> !stop_allowed)
        else $error("stop allowed with pin high");

    // level mode halt gate
    a_halt_gate: assert property (@(posedge clock) disable iff (rst)
        cur.mode == DETECT_LEVEL && any_high |=> !halt_allowed)
        else $error("halt allowed with pin high");

    // debounce halt always allowed
    a_halt_free: assert property (@(posedge clock) disable iff (rst)
        cur.mode_taken && cur.mode == DETECT_FILTER |=> halt_allowed)
        else $error("halt blocked in debounce mode");

    // interrupt follows flag when enabled
    a_irq_follow: assert property (@(posedge clock) disable iff (rst)
        set_flag && interrupt_enable0 |=> interrupt_request && halt_release_request0)
        else $error("interrupt not raised");

    // debounce stop release needs both enables
    a_stop_enable: assert property (@(posedge clock) disable iff (rst)
        stop_release && cur.mode == DETECT_FILTER |-> $past(port_stop_release_enable)
        && $past(cur.sef))
        else $error("stop release without enables");

    // mode fixed once taken
    a_mode_static: assert property (@(posedge clock) disable iff (rst)
        cur.mode_taken |=> $stable(cur.mode))
        else $error("detection mode changed");

    // filtered change while armed and clear lands in the flag
    a_filter_edge: assert property (@(posedge clock) disable iff (rst)
        cur.mode_taken && cur.mode == DETECT_FILTER && cur.sef && !cur.scf
        && filt != cur.prev_filt |=> cur.scf)
        else $error("filtered change did not set flag");

    // disarmed port never detects
    a_disarmed_quiet: assert property (@(posedge clock) disable iff (rst)
        !cur.sef |-> !set_flag)
        else $error("detection while disarmed");

    // every setting edge gives one halt release pulse
    a_halt_pulse: assert property (@(posedge clock) disable iff (rst)
        set_flag |=> halt_release)
        else $error("no halt release on flag set");

    // level mode stop release when armed and a pin is high
    a_stop_level: assert property (@(posedge clock) disable iff (rst)
        power_state == PWR_STOP && cur.mode == DETECT_LEVEL && cur.sef && !cur.scf
        && any_high |=> stop_release)
        else $error("level mode stop release missing");

    // return to stop only while the flag is still clear
    a_back_stop: assert property (@(posedge clock) disable iff (rst)
        return_to_stop |-> !port_start_cond_flag)
        else $error("return to stop after flag set");

    // clock select loads the new value
    a_sel_load: assert property (@(posedge clock) disable iff (rst)
        filter_clock_select_instr |=> cur.sel == $past(filter_clock_select_value))
        else $error("filter clock select not loaded");

endmodule

//--- tb/switch_bank.sv
`timescale 1ns/1ns

// external switches on the four port pins, with optional contact bounce on pin 0
module switch_bank
(
    input wire logic clock,
    input wire logic [3:0] level,
    input wire logic chatter,
    output logic [3:0] pins
);
    // bounce toggles every cycle, far quicker than any filter interval
    logic bounce = 1'b0;

    // bounce only while asked, settles to the held level afterwards
    always @(posedge clock)
    begin
        bounce <= chatter ? ~bounce : 1'b0;
    end

    // the switch keeps its level until the bench changes it
    assign pins = level ^ {3'h0, bounce};
endmodule

//--- tb/port_d_wake_detect_test.sv
`timescale 1ns/1ns

module port_d_wake_detect_test;
    import port_d_wake_pkg::*;
    // short filter counts keep the run brief
    localparam int unsigned SLOW = 40;
    localparam int unsigned MID = 10;
    localparam int unsigned FAST = 3;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [3:0] level = 4'h0; // switch levels asked of the partner
    logic chatter = 1'b0;
    logic [3:0] wake_port;
    logic strap = 1'b0, arm = 1'b0, sel_go = 1'b0, sre = 1'b0, ien = 1'b1;
    logic ack = 1'b0, pa = 1'b0, pc = 1'b0, clr = 1'b1;
    logic [1:0] sel_val = 2'h0;
    power_state_t pwr = PWR_RUN;
    logic flag, fa, fc, sef, hrf, irq, hrel, srel, rts, hok, sok;
    logic [2:0] seen; // sticky pulses: halt, stop, back to stop
    int bad_count = 0;
    int comparisons = 0;
    int n;

    always #5 clock = ~clock;

    switch_bank switch_bank_inst (.clock(clock), .level(level), .chatter(chatter),
        .pins(wake_port));

    port_d_wake_detect #(.SLOW_CYCLES(SLOW), .MID_CYCLES(MID), .FAST_CYCLES(FAST))
        port_d_wake_detect_inst (.clock(clock), .rst(rst), .wake_port(wake_port),
        .debounce_strap(strap), .arm_wake_instruction(arm),
        .filter_clock_select_instr(sel_go), .filter_clock_select_value(sel_val),
        .port_stop_release_enable(sre), .interrupt_enable0(ien),
        .halt_release_ack0(ack), .porta_set(pa), .portc_set(pc), .power_state(pwr),
        .port_start_cond_flag(flag), .porta_start_cond_flag(fa),
        .portc_start_cond_flag(fc), .port_switch_enable_flag(sef),
        .halt_release_request0(hrf), .interrupt_request(irq), .halt_release(hrel),
        .stop_release(srel), .return_to_stop(rts), .halt_allowed(hok),
        .stop_allowed(sok));

    // one-cycle pulses are caught here so scenarios need not poll every edge
    always @(posedge clock)
    begin
        if (clr)
            seen <= 3'h0;
        else
            seen <= seen | {hrel === 1'b1, srel === 1'b1, rts === 1'b1};
    end

    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one-cycle strobe: 0 arm, 1 select, 2 ack, 3 other ports, 4 clear seen
    task automatic strobe(input int which);
        @(posedge clock);
        case (which)
            0: arm <= 1'b1;
            1: sel_go <= 1'b1;
            2: ack <= 1'b1;
            3: {pa, pc} <= 2'h3;
            default: clr <= 1'b1;
        endcase
        @(posedge clock);
        {arm, sel_go, ack, pa, pc, clr} <= 6'h00;
        #1;
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask

    // bounded wait for the start flag, n counts the cycles taken
    task automatic wait_flag(input int lim);
        n = 0;
        while (flag !== 1'b1 && n < lim)
        begin
            @(posedge clock);
            #1;
            n++;
        end
    endtask

    task automatic do_reset(input logic mode);
        @(posedge clock);
        rst <= 1'b1;
        strap <= mode;
        level <= 4'h0;
        pwr <= PWR_RUN;
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        tick(3);
        chk({flag, sef, hrf, irq}, 4'h0);
    endtask

    task automatic level_mode;
        do_reset(1'b0);
        strobe(0);
        strobe(4);
        chk({sef, hok, sok}, 4'h7);
        level <= 4'h4;
        wait_flag(20);
        tick(1); // pulse catcher lags the pulse by one edge
        chk({flag, hrf, irq, seen[2]}, 4'hF);
        chk({hok, sok}, 4'h0);
        strobe(2);
        strobe(4);
        level <= 4'h0;
        tick(8);
        level <= 4'h2;
        tick(10);
        chk({flag, hrf, seen[2]}, 4'h4);
        strobe(3);
        chk({fa, fc}, 4'h3);
        level <= 4'h0;
        strobe(0);
        chk({flag, fa, fc}, 4'h0);
        pwr <= PWR_STOP;
        strobe(4);
        level <= 4'h1;
        tick(12);
        chk(seen[1], 4'h1);
    endtask

    task automatic filter_mode;
        int sel_tab[3] = '{2, 1, 0};
        int cyc_tab[3] = '{FAST, MID, SLOW};
        do_reset(1'b1);
        strap <= 1'b0;
        strobe(0);
        level <= 4'h1;
        tick(5);
        level <= 4'h0;
        wait_flag(80);
        chk(flag, 4'h0);
        level <= 4'h1;
        chatter <= 1'b1;
        tick(8);
        chatter <= 1'b0;
        wait_flag(80);
        chk({flag, 3'(n >= SLOW && n <= SLOW + 15)}, 4'h9);
        chk({hok, sok}, 4'h2);
        strobe(0);
        strobe(4);
        level <= 4'h0;
        wait_flag(80);
        tick(1);
        chk({flag, seen[2]}, 4'h3);
        ien <= 1'b0;
        strobe(2);
        for (int i = 0; i < 3; i++)
        begin
            sel_val <= 2'(sel_tab[i]);
            strobe(1);
            strobe(0);
            level <= level ^ 4'h8;
            wait_flag(80);
            chk({flag, 3'(n >= cyc_tab[i] && n <= cyc_tab[i] + 15)}, 4'h9);
            chk({hrf, irq}, 4'h2);
        end
        level <= 4'h0;
        tick(60);
        strobe(0);
        pwr <= PWR_STOP;
        strobe(4);
        level <= 4'h1;
        tick(10);
        level <= 4'h0;
        tick(10);
        chk(seen[1], 4'h0);
        sre <= 1'b1;
        strobe(4);
        level <= 4'h1;
        tick(10);
        level <= 4'h0;
        tick(10);
        chk({flag, seen[1:0]}, 4'h3);
        strobe(4);
        level <= 4'h1;
        tick(8);
        pwr <= PWR_HALT;
        wait_flag(80);
        chk({flag, seen[1:0]}, 4'h6);
    endtask

    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // main sequence
    initial
    begin
        level_mode();
        filter_mode();
        test_done();
    end

    // watchdog, several times the expected run length
    initial
    begin
        repeat (5000) @(posedge clock);
        bad_count++;
        $display("watchdog expired at %0t", $time);
        test_done();
    end
endmodule
